// ==== pkg/hppar_pkg.sv ====
// hppar_pkg: constants shared by the host port page address / ready block
// assumes a 50 MHz core clock and 32-bit register bus addressing by byte
package hppar_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [31:0] ADDR_PAGE_HIGH = 32'h4000_000c;
  localparam logic [31:0] ADDR_PAGE_MID = 32'h4000_0010;
  localparam logic [31:0] ADDR_CONFIG = 32'h4000_0014;
  localparam logic [31:0] ADDR_STATUS = 32'h4000_0018;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam int CFG_PAGED_BIT = 0;
  localparam int CFG_NONMUX_BIT = 1;
  localparam int CFG_FULLWORD_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LATE_BIT = 1;
  localparam int STAT_COUNT_LSB = 8;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;

  // ----------------------------------------
  // host access control codes
  // ----------------------------------------
  localparam logic [1:0] CTL_CONTROL_PORT = 2'h0;
  localparam logic [1:0] CTL_DATA_AUTOINC = 2'h1;
  localparam logic [1:0] CTL_ADDRESS_PORT = 2'h2;
  localparam logic [1:0] CTL_DATA_FIXED = 2'h3;

  // ----------------------------------------
  // timing: h is half the peripheral clock period
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int HALF_PERIOD_NS = CLK_PERIOD_NS / 2;
  localparam int READ_READY_MAX_NS = 10 * 2 * HALF_PERIOD_NS + 20;
  localparam int FLUSH_READY_MAX_NS = 40 * 2 * HALF_PERIOD_NS + 20;
  localparam logic [7:0] READ_READY_CYCLES = 8'(READ_READY_MAX_NS / CLK_PERIOD_NS);
  localparam logic [7:0] FLUSH_READY_CYCLES = 8'(FLUSH_READY_MAX_NS / CLK_PERIOD_NS);

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  localparam int PIN_WIDTH = 55;
  localparam logic [54:0] PIN_IDLE = {3'h7, 52'h0};

  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_PREF, ST_POP, ST_WRITE, ST_FLUSH} hppar_state_type;

endpackage

// ==== sim/hppar_host_model.sv ====
// hppar_host_model: external host processor on the host pins
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
`default_nettype none
module hppar_host_model (
  input wire logic i_core_clk,
  input wire logic i_host_ready_n,
  input wire logic [31:0] i_host_data_bus,
  output logic o_host_chip_select_n,
  output logic o_host_addr_strobe_n,
  output logic o_host_data_strobe_n,
  output logic o_host_read_write,
  output logic o_host_halfword_select,
  output logic [1:0] o_host_access_control,
  output logic [31:0] o_host_data_bus,
  output logic o_done,
  output logic [31:0] o_data,
  output logic [7:0] o_cyc
);
  initial begin
    {o_host_chip_select_n, o_host_addr_strobe_n, o_host_data_strobe_n} = 3'h7;
    {o_host_read_write, o_host_halfword_select, o_host_access_control, o_done} = 5'h00;
    o_host_data_bus = 32'h0000_0000;
  end
  task automatic xfer(input logic rd, input logic [1:0] ctl, input logic [31:0] wd, input logic chkd);
    int n;
    @(posedge i_core_clk);
    o_host_chip_select_n <= 1'b0;
    o_host_read_write <= rd;
    o_host_access_control <= ctl;
    o_host_data_bus <= wd;
    @(posedge i_core_clk);
    o_host_data_strobe_n <= 1'b0;
    // a write is taken at the strobe's rise, so ready only moves after it
    if (!rd) begin
      repeat (8) @(posedge i_core_clk);
      o_host_data_strobe_n <= 1'b1;
    end
    for (n = 0; n < 16 && i_host_ready_n !== 1'b1; n++) @(negedge i_core_clk);
    while (n < 200 && i_host_ready_n !== 1'b0) begin
      @(negedge i_core_clk);
      n++;
    end
    o_data = i_host_data_bus;
    o_cyc = 8'(n);
    @(posedge i_core_clk);
    o_done <= rd & chkd;
    o_host_data_strobe_n <= 1'b1;
    o_host_chip_select_n <= 1'b1;
    // released bus shows the inverse, never a stale match
    o_host_data_bus <= ~wd;
    @(posedge i_core_clk);
    o_done <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic astb;
    int n;
    @(posedge i_core_clk);
    o_host_chip_select_n <= 1'b0;
    o_host_addr_strobe_n <= 1'b0;
    for (n = 0; n < 50 && i_host_ready_n !== 1'b1; n++) @(negedge i_core_clk);
    o_cyc = 8'(n);
    @(posedge i_core_clk);
    o_host_addr_strobe_n <= 1'b1;
    o_host_chip_select_n <= 1'b1;
    for (n = 0; n < 50 && i_host_ready_n !== 1'b0; n++) @(negedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// ==== sim/hppar_monitor.sv ====
// hppar_monitor: port assertions for hppar_top
// assumes one core clock and an async active-high reset
`timescale 1ns/1ps
`default_nettype none
module hppar_monitor
  import hppar_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [31:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic i_host_chip_select_n,
  input wire logic i_host_addr_strobe_n,
  input wire logic i_host_data_strobe_n,
  input wire logic i_host_read_write,
  input wire logic [1:0] i_host_access_control,
  input wire logic o_host_data_bus_oe_n,
  input wire logic o_host_ready_n,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [31:0] o_mem_addr,
  input wire logic i_mem_ack
);
  // ----------------
  // register mirrors
  // ----------------
  // bound covers slow memory plus one prefetch still in flight
  localparam int READY_BOUND = 60;
  logic [7:0] hi_m;
  logic [7:0] mid_m;
  logic [2:0] cfg_m;
  wire logic paged = cfg_m[CFG_PAGED_BIT] | cfg_m[CFG_NONMUX_BIT];
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      hi_m <= PAGE_RESET;
      mid_m <= PAGE_RESET;
      cfg_m <= 3'h0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == ADDR_PAGE_HIGH) hi_m <= i_reg_wdata[7:0];
      if (i_reg_addr == ADDR_PAGE_MID) mid_m <= i_reg_wdata[7:0];
      if (i_reg_addr == ADDR_CONFIG) cfg_m <= i_reg_wdata[2:0];
    end
  end
  // ----------------
  // assertions
  // ----------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000)
    else $error("read data not cleared");
  rd_high_a: assert property (i_reg_rd && i_reg_addr == ADDR_PAGE_HIGH
    |=> o_reg_rdata == {24'h00_0000, hi_m}) else $error("page high readback wrong");
  rd_mid_a: assert property (i_reg_rd && i_reg_addr == ADDR_PAGE_MID
    |=> o_reg_rdata == {24'h00_0000, mid_m}) else $error("page mid readback wrong");
  page_high_a: assert property ($rose(o_mem_req) && paged |-> o_mem_addr[31:24] == hi_m)
    else $error("address bits 31:24 not from page high");
  page_mid_a: assert property ($rose(o_mem_req) && paged |-> o_mem_addr[23:16] == mid_m)
    else $error("address bits 23:16 not from page mid");
  mem_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("memory request dropped before ack");
  ready_bound_a: assert property ($rose(o_host_ready_n) |-> ##[1:READY_BOUND] !o_host_ready_n)
    else $error("ready not returned in time");
  addr_strobe_a: assert property ($fell(i_host_addr_strobe_n) && !i_host_chip_select_n
    |-> ##[1:10] o_host_ready_n) else $error("address strobe did not drop ready");
  direct_read_a: assert property ($fell(i_host_data_strobe_n) && !i_host_chip_select_n
    && i_host_read_write && !i_host_access_control[0] |-> ##[1:10] (!o_host_ready_n && !o_host_data_bus_oe_n))
    else $error("port read not answered directly");
  cover property ($rose(o_mem_req) && paged);
  cover property (i_mem_ack && o_mem_we);
  cover property ($fell(i_host_addr_strobe_n));
endmodule

bind hppar_top hppar_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_mon (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_host_chip_select_n(i_host_chip_select_n), .i_host_addr_strobe_n(i_host_addr_strobe_n),
  .i_host_data_strobe_n(i_host_data_strobe_n), .i_host_read_write(i_host_read_write),
  .i_host_access_control(i_host_access_control), .o_host_data_bus_oe_n(o_host_data_bus_oe_n),
  .o_host_ready_n(o_host_ready_n), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
  .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack)
);
`default_nettype wire

// ==== sim/tb.sv ====
// tb: self-checking bench for hppar_top
// assumes hppar_host_model on the host pins and an inline memory responder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hppar_pkg::*;
  typedef struct {string nm; logic [31:0] v;} hppar_note_type;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [31:0] i_reg_addr = 32'h0000_0000;
  logic [31:0] i_reg_wdata = 32'h0000_0000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [15:0] i_host_addr = 16'h0000;
  logic i_mem_ack = 1'b0;
  logic [31:0] i_mem_rdata = 32'h0000_0000;
  wire logic [31:0] o_reg_rdata, o_host_data_bus, o_mem_addr, o_mem_wdata, i_host_data_bus, h_data;
  wire logic i_host_chip_select_n, i_host_addr_strobe_n, i_host_data_strobe_n, i_host_read_write;
  wire logic i_host_halfword_select, o_host_data_bus_oe_n, o_host_ready_n, o_mem_req, o_mem_we, h_done;
  wire logic [1:0] i_host_access_control;
  wire logic [7:0] h_cyc;
  int error_cnt = 0;
  int n_tests = 0;
  hppar_note_type notes[$];
  logic rd_d = 1'b0;
  logic slow = 1'b0;
  logic mbusy = 1'b0;
  logic [2:0] mcnt = 3'h0;
  logic [15:0] pg;
  logic [15:0] lo;
  logic [31:0] w;
  logic [7:0] lr;
  always #10 i_core_clk = ~i_core_clk;
  hppar_top i_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_host_chip_select_n(i_host_chip_select_n), .i_host_addr_strobe_n(i_host_addr_strobe_n),
    .i_host_data_strobe_n(i_host_data_strobe_n), .i_host_read_write(i_host_read_write),
    .i_host_halfword_select(i_host_halfword_select), .i_host_access_control(i_host_access_control),
    .i_host_addr(i_host_addr), .i_host_data_bus(i_host_data_bus), .o_host_data_bus(o_host_data_bus),
    .o_host_data_bus_oe_n(o_host_data_bus_oe_n), .o_host_ready_n(o_host_ready_n), .o_mem_req(o_mem_req),
    .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata)
  );
  hppar_host_model i_host (
    .i_core_clk(i_core_clk), .i_host_ready_n(o_host_ready_n), .i_host_data_bus(o_host_data_bus),
    .o_host_chip_select_n(i_host_chip_select_n), .o_host_addr_strobe_n(i_host_addr_strobe_n),
    .o_host_data_strobe_n(i_host_data_strobe_n), .o_host_read_write(i_host_read_write),
    .o_host_halfword_select(i_host_halfword_select), .o_host_access_control(i_host_access_control),
    .o_host_data_bus(i_host_data_bus), .o_done(h_done), .o_data(h_data), .o_cyc(h_cyc)
  );
  // ----------------
  // memory responder and result watcher
  // ----------------
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      i_mem_ack <= 1'b0;
      mbusy <= 1'b0;
    end else if (i_mem_ack || !mbusy) begin
      i_mem_ack <= 1'b0;
      i_mem_rdata <= ~i_mem_rdata;
      mbusy <= o_mem_req && !i_mem_ack;
      mcnt <= slow ? 3'($urandom_range(5, 1)) : 3'h0;
    end else if (mcnt != 3'h0) begin
      mcnt <= mcnt - 3'h1;
      i_mem_rdata <= ~i_mem_rdata;
    end else begin
      mbusy <= 1'b0;
      i_mem_ack <= 1'b1;
      i_mem_rdata <= {~o_mem_addr[31:16], o_mem_addr[31:16]};
    end
  end
  always @(posedge i_core_clk) begin
    rd_d <= i_reg_rd;
    if (rd_d) take(o_reg_rdata);
    if (h_done) take(h_data);
    if (i_mem_ack && o_mem_we) begin
      take(o_mem_wdata);
      take({16'h0000, o_mem_addr[31:16]});
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic take(input logic [31:0] seen);
    hppar_note_type n;
    n = '{"no_note", 32'hxxxx_xxxx};
    if (notes.size() > 0) n = notes.pop_front();
    chk(n.nm, seen, n.v);
  endtask
  task automatic note(input string nm, input logic [31:0] v);
    notes.push_back('{nm, v});
  endtask
  task automatic rg(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= wr;
    i_reg_rd <= ~wr;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
  endtask
  task automatic hx(input logic rd, input logic [1:0] ctl, input logic [31:0] wd, input string nm,
                    input logic [31:0] e, input logic [7:0] lim);
    if (nm != "") note(nm, e);
    i_host.xfer(rd, ctl, wd, nm != "");
    chk("ready_wait", {31'h0000_0000, h_cyc <= lim}, 32'h0000_0001);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_core_clk);
    error_cnt++;
    complete_run;
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    void'($urandom(32'h1423fbe1));
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      w = i ? ADDR_PAGE_MID : ADDR_PAGE_HIGH;
      lr = 8'($urandom);
      note("page_reset", 32'h0000_0000);
      rg(1'b0, w, 32'h0000_0000);
      rg(1'b1, w, {24'h00_0000, lr});
      note("page_readback", {24'h00_0000, lr});
      rg(1'b0, w, 32'h0000_0000);
    end
    rg(1'b1, 32'h4000_0008, 32'h0000_00ff);
    note("unmapped", 32'h0000_0000);
    rg(1'b0, 32'h4000_0008, 32'h0000_0000);
    pg = 16'($urandom);
    rg(1'b1, ADDR_PAGE_HIGH, {24'h00_0000, pg[15:8]});
    rg(1'b1, ADDR_PAGE_MID, {24'h00_0000, pg[7:0]});
    // mode 0 non-muxed with prompt memory, mode 1 paged muxed with slow memory
    for (int m = 0; m < 2; m++) begin
      slow <= m[0];
      lo = 16'($urandom) & 16'h0ff0;
      i_host_addr <= lo;
      lr = m ? 8'hc8 : READ_READY_CYCLES;
      rg(1'b1, ADDR_CONFIG, m ? 32'h0000_0005 : 32'h0000_0006);
      if (m) hx(1'b0, CTL_ADDRESS_PORT, {16'h0000, lo}, "", 32'h0000_0000, 8'hc8);
      hx(1'b1, CTL_DATA_FIXED, 32'h0000_0000, "fixed_read", {~pg, pg}, lr);
      hx(1'b1, CTL_DATA_AUTOINC, 32'h0000_0000, "autoinc_miss", {~pg, pg}, lr);
      repeat (80) @(posedge i_core_clk);
      for (int k = 0; k < 2; k++) hx(1'b1, CTL_DATA_AUTOINC, 32'h0000_0000, "autoinc_hit", {~pg, pg}, 8'h09);
      hx(1'b1, CTL_CONTROL_PORT, 32'h0000_0000, "", 32'h0000_0000, 8'h09);
      hx(1'b0, CTL_ADDRESS_PORT, {16'h0000, lo}, "", 32'h0000_0000, FLUSH_READY_CYCLES);
      w = $urandom;
      note("mem_wdata", w);
      note("mem_page", {16'h0000, pg});
      hx(1'b0, CTL_DATA_FIXED, w, "", 32'h0000_0000, 8'hc8);
    end
    i_host.astb;
    chk("addr_strobe_ready", {31'h0000_0000, h_cyc <= 8'h09}, 32'h0000_0001);
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    note("page_after_reset", 32'h0000_0000);
    rg(1'b0, ADDR_PAGE_HIGH, 32'h0000_0000);
    repeat (4) @(posedge i_core_clk);
    complete_run;
  end
endmodule
`default_nettype wire

// ==== verilog/hppar_fifo_mem.sv ====
// hppar_fifo_mem: storage for the read prefetch words
// assumes one writer and one reader on the core clock; read data registered
`timescale 1ns/1ps
`default_nettype none
module hppar_fifo_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_wr_en,
  input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array: contents only matter once pushed
  always_ff @(posedge i_core_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule
`default_nettype wire

// ==== verilog/hppar_top.sv ====
// hppar_top: host port page address registers, prefetch and ready handshake
// assumes host pins are asynchronous and an internal memory port that acks once
// What this block does
// - page high byte supplies internal address bits 31:24 when paged or non-muxed
// - page middle byte supplies internal address bits 23:16 when paged or non-muxed
// - uncached data reads signal ready on the memory ack; a wait past ten doubled half-periods plus 20 ns only sets late
// - address write with buffered data holds ready until the buffer is resolved
// - ready goes inactive soon after the address strobe falls
// - read data is valid no later than ready asserts
// - control and address port reads return directly without a memory wait
// - paged multiplexed mode takes only the lower 16 bits from the host
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module hppar_top #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [31:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_host_chip_select_n,
  input wire logic i_host_addr_strobe_n,
  input wire logic i_host_data_strobe_n,
  input wire logic i_host_read_write,
  input wire logic i_host_halfword_select,
  input wire logic [1:0] i_host_access_control,
  input wire logic [15:0] i_host_addr,
  input wire logic [31:0] i_host_data_bus,
  output logic [31:0] o_host_data_bus,
  output logic o_host_data_bus_oe_n,
  output logic o_host_ready_n,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata
);
  import hppar_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] FIFO_FULL = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] COUNT_ONE = CW'(1);
  localparam logic [PW-1:0] PTR_ONE = PW'(1);

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic [PIN_WIDTH-1:0] sync1, sync2, sync3, pins;
  wire [PIN_WIDTH-1:0] pin_raw = {i_host_chip_select_n, i_host_addr_strobe_n, i_host_data_strobe_n,
    i_host_read_write, i_host_halfword_select, i_host_access_control, i_host_addr, i_host_data_bus};
  wire [PIN_WIDTH-1:0] pin_differ = sync2 ^ sync3;
  wire [PIN_WIDTH-1:0] next_pins = (sync3 & ~pin_differ) | (pins & pin_differ);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
      pins <= PIN_IDLE;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      pins <= next_pins;
    end
  end

  wire cs_n = pins[54];
  wire as_n = pins[53];
  wire ds_n = pins[52];
  wire pin_rw = pins[51];
  wire pin_hw = pins[50];
  wire [1:0] pin_ctl = pins[49:48];
  wire [15:0] pin_addr = pins[47:32];
  wire [31:0] pin_data = pins[31:0];

  // ----------------------------------------
  // state
  // ----------------------------------------
  hppar_state_type state;
  logic ds_prev, as_prev, pend_rd, pend_wr, acc_rw, acc_hw, pf_on, late;
  logic [1:0] acc_ctl;
  logic [31:0] wr_data, addr_port, ctrl_port, fetch_addr;
  logic [7:0] page_high, page_mid, wait_cnt;
  logic cfg_paged, cfg_nonmux, cfg_fullword;
  logic [PW-1:0] wptr, rptr;
  logic [CW-1:0] fifo_count;
  logic [31:0] fifo_rdata;

  wire ds_fall = ds_prev & ~ds_n & ~cs_n;
  wire ds_rise = ~ds_prev & ds_n & ~cs_n;
  wire as_fall = as_prev & ~as_n;
  wire rd_evt = ds_fall & pin_rw;
  wire wr_evt = ds_rise & ~acc_rw;

  // paged mode keeps only 16 host bits
  // page bytes above the host half
  wire [15:0] host_low = cfg_nonmux ? pin_addr : addr_port[15:0];
  wire use_page = cfg_nonmux | cfg_paged;
  wire [31:0] eff_addr = use_page ? {page_high, page_mid, host_low} : addr_port;

  wire idle = (state == ST_IDLE);
  wire take_rd = idle & pend_rd;
  wire take_wr = idle & pend_wr & ~pend_rd;
  wire fifo_has = (fifo_count != '0);
  wire fifo_room = (fifo_count != FIFO_FULL);
  wire start_pref = idle & ~pend_rd & ~pend_wr & pf_on & fifo_room;
  wire pop_now = take_rd & (acc_ctl == CTL_DATA_AUTOINC) & fifo_has;
  wire push_now = (state == ST_PREF) & i_mem_ack;
  wire [31:0] addr_next = addr_port + WORD_STEP;
  wire [31:0] addr_written = cfg_fullword ? wr_data :
    (acc_hw ? {wr_data[15:0], addr_port[15:0]} : {addr_port[31:16], wr_data[15:0]});
  wire busy_wait = (state == ST_READ) | (state == ST_WRITE) | (state == ST_FLUSH);
  wire [7:0] wait_limit = (state == ST_FLUSH) ? FLUSH_READY_CYCLES : READ_READY_CYCLES;

  hppar_fifo_mem #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_wr_en(push_now),
    .i_wr_addr(wptr),
    .i_wr_data(i_mem_rdata),
    .i_rd_en(pop_now),
    .i_rd_addr(rptr),
    .o_rd_data(fifo_rdata)
  );

  // ----------------------------------------
  // strobe capture
  // ----------------------------------------
  // set beats clear so a strobe seen while busy is kept
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ds_prev <= 1'b1;
      as_prev <= 1'b1;
      pend_rd <= 1'b0;
      pend_wr <= 1'b0;
      acc_rw <= 1'b1;
      acc_hw <= 1'b0;
      acc_ctl <= CTL_CONTROL_PORT;
      wr_data <= 32'h0000_0000;
    end else begin
      ds_prev <= ds_n;
      as_prev <= as_n;
      pend_rd <= rd_evt | (pend_rd & ~take_rd);
      pend_wr <= wr_evt | (pend_wr & ~take_wr);
      if (ds_fall) begin
        acc_rw <= pin_rw;
        acc_hw <= pin_hw;
        acc_ctl <= pin_ctl;
      end
      if (ds_rise) begin
        wr_data <= pin_data;
      end
    end
  end

  // ----------------------------------------
  // access engine
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      o_host_ready_n <= 1'b0;
      o_host_data_bus <= 32'h0000_0000;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= 32'h0000_0000;
      o_mem_wdata <= 32'h0000_0000;
      addr_port <= 32'h0000_0000;
      ctrl_port <= 32'h0000_0000;
      fetch_addr <= 32'h0000_0000;
      pf_on <= 1'b0;
      wptr <= '0;
      rptr <= '0;
      fifo_count <= '0;
    end else begin
      if (push_now) begin
        wptr <= wptr + PTR_ONE;
      end
      fifo_count <= fifo_count + (push_now ? COUNT_ONE : '0) - (pop_now ? COUNT_ONE : '0);
      if (pop_now) begin
        rptr <= rptr + PTR_ONE;
      end
      case (state)
        ST_IDLE: begin
          // host must wait on this level
          o_host_ready_n <= as_fall | rd_evt | wr_evt;
          if (take_rd) begin
            case (acc_ctl)
              CTL_CONTROL_PORT: o_host_data_bus <= ctrl_port;
              CTL_ADDRESS_PORT: o_host_data_bus <= addr_port;
              default: begin
                o_host_ready_n <= 1'b1;
                if (pop_now) begin
                  state <= ST_POP;
                end else begin
                  pf_on <= 1'b0;
                  o_mem_req <= 1'b1;
                  o_mem_we <= 1'b0;
                  o_mem_addr <= eff_addr;
                  state <= ST_READ;
                end
              end
            endcase
          end else if (take_wr) begin
            case (acc_ctl)
              CTL_CONTROL_PORT: ctrl_port <= wr_data;
              CTL_ADDRESS_PORT: begin
                addr_port <= addr_written;
                pf_on <= 1'b0;
                if (fifo_has) begin
                  o_host_ready_n <= 1'b1;
                  state <= ST_FLUSH;
                end
              end
              default: begin
                // stale prefetch would hide this write
                pf_on <= 1'b0;
                wptr <= '0;
                rptr <= '0;
                fifo_count <= '0;
                o_host_ready_n <= 1'b1;
                o_mem_req <= 1'b1;
                o_mem_we <= 1'b1;
                o_mem_addr <= eff_addr;
                o_mem_wdata <= wr_data;
                state <= ST_WRITE;
              end
            endcase
          end else if (start_pref) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            o_mem_addr <= fetch_addr;
            state <= ST_PREF;
          end
        end
        ST_READ: begin
          if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_host_data_bus <= i_mem_rdata;
            o_host_ready_n <= 1'b0;
            if (acc_ctl == CTL_DATA_AUTOINC) begin
              addr_port <= addr_next;
              fetch_addr <= o_mem_addr + WORD_STEP;
              pf_on <= 1'b1;
            end
            state <= ST_IDLE;
          end
        end
        ST_PREF: begin
          // strobe during a prefetch still drops ready
          o_host_ready_n <= o_host_ready_n | as_fall | rd_evt | wr_evt;
          if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            fetch_addr <= fetch_addr + WORD_STEP;
            state <= ST_IDLE;
          end
        end
        ST_POP: begin
          o_host_data_bus <= fifo_rdata;
          o_host_ready_n <= 1'b0;
          addr_port <= addr_next;
          state <= ST_IDLE;
        end
        ST_WRITE: begin
          if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_host_ready_n <= 1'b0;
            if (acc_ctl == CTL_DATA_AUTOINC) begin
              addr_port <= addr_next;
            end
            state <= ST_IDLE;
          end
        end
        ST_FLUSH: begin
          wptr <= '0;
          rptr <= '0;
          fifo_count <= '0;
          o_host_ready_n <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // host data drive and latency watch
  // ----------------------------------------
  // a late flag only reports contention; ready is never forced early
  wire reg_wr_status = i_reg_wr & (i_reg_addr == ADDR_STATUS);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_data_bus_oe_n <= 1'b1;
      wait_cnt <= 8'h00;
      late <= 1'b0;
    end else begin
      o_host_data_bus_oe_n <= ~(~cs_n & ~ds_n & pin_rw);
      wait_cnt <= busy_wait ? wait_cnt + 8'h01 : 8'h00;
      late <= (busy_wait & (wait_cnt == wait_limit)) |
        (late & ~(reg_wr_status & i_reg_wdata[STAT_LATE_BIT]));
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  wire reg_wr_high = i_reg_wr & (i_reg_addr == ADDR_PAGE_HIGH);
  wire reg_wr_mid = i_reg_wr & (i_reg_addr == ADDR_PAGE_MID);
  wire reg_wr_cfg = i_reg_wr & (i_reg_addr == ADDR_CONFIG);
  wire [31:0] status_word = (32'(fifo_count) << STAT_COUNT_LSB) |
    (32'(late) << STAT_LATE_BIT) | (32'(~idle) << STAT_BUSY_BIT);
  wire [31:0] cfg_word = (32'(cfg_paged) << CFG_PAGED_BIT) | (32'(cfg_nonmux) << CFG_NONMUX_BIT) |
    (32'(cfg_fullword) << CFG_FULLWORD_BIT);
  wire [31:0] reg_mux = (i_reg_addr == ADDR_PAGE_HIGH) ? {24'h00_0000, page_high} :
    (i_reg_addr == ADDR_PAGE_MID) ? {24'h00_0000, page_mid} :
    (i_reg_addr == ADDR_CONFIG) ? cfg_word :
    (i_reg_addr == ADDR_STATUS) ? status_word : 32'h0000_0000;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      page_high <= PAGE_RESET;
      page_mid <= PAGE_RESET;
      cfg_paged <= 1'b0;
      cfg_nonmux <= 1'b0;
      cfg_fullword <= 1'b0;
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      o_reg_rdata <= i_reg_rd ? reg_mux : 32'h0000_0000;
      if (reg_wr_high) begin
        page_high <= i_reg_wdata[7:0];
      end
      if (reg_wr_mid) begin
        page_mid <= i_reg_wdata[7:0];
      end
      if (reg_wr_cfg) begin
        cfg_paged <= i_reg_wdata[CFG_PAGED_BIT];
        cfg_nonmux <= i_reg_wdata[CFG_NONMUX_BIT];
        cfg_fullword <= i_reg_wdata[CFG_FULLWORD_BIT];
      end
    end
  end

endmodule
`default_nettype wire
